/* File: scs_clock_select.sv */
/*
 * Core clock source selector: internal oscillator enable and prescale,
 * glitch-free choice among internal, external and PLL sources, divided
 * clock for a port pin, and ready / valid / lock status.
 * Assumes oscillator levels arrive synchronous to clock and toggle well
 * below half its rate; registers are reached on a plain register port.
 */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - one write to oscillator control enables the internal oscillator and sets its prescale; selection is in the source register.
// - oscillator control bit 6 reads 1 only while internal oscillator runs settled.
// - source field 00 internal, 01 external, 10 PLL, 11 reserved.
// - external oscillator stays available to peripherals whatever the core source.
// - source switches on the fly, only to an enabled and settled source.
// - crystal valid rises once the external oscillator has settled.
// - PLL locked flag rises once the PLL holds the correct frequency.
// - after any reset the internal oscillator drives the core clock.
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int INT_SETTLE_EDGES = 8, // internal oscillator edges to ready
    parameter int XTAL_SETTLE_EDGES = 16 // external oscillator edges to valid
) (
    input wire logic clock, // block clock, 25 MHz
    input wire logic reset, // synchronous, active high
    input wire logic [7:0] sfr_addr, // register address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_write, // write strobe, one cycle
    output logic [7:0] sfr_rdata, // read data, one cycle after address
    input wire logic int_osc_in, // internal oscillator level
    input wire logic ext_osc_in, // external oscillator level
    input wire logic ext_osc_enable, // external circuit enabled
    input wire logic pll_clk_in, // PLL output level
    input wire logic pll_lock_in, // PLL lock detector
    output logic core_clock, // selected core clock
    output logic clock_out, // divided core clock for port pin
    output logic ext_periph_clock, // external clock for peripherals
    output logic int_osc_enable, // internal oscillator enable
    output logic crystal_valid, // external oscillator settled
    output logic pll_locked // PLL lock flag
);
    initial begin
        if (INT_SETTLE_EDGES < 1 || INT_SETTLE_EDGES > 255 ||
            XTAL_SETTLE_EDGES < 1 || XTAL_SETTLE_EDGES > 255) begin
            $error("settle edge counts must lie in 1..255");
        end
    end

    localparam logic [7:0] INT_SETTLE = INT_SETTLE_EDGES[7:0];
    localparam logic [7:0] XTAL_SETTLE = XTAL_SETTLE_EDGES[7:0];

    logic [1:0] int_osc_divide_reg;
    logic [1:0] core_clock_source_reg;
    logic [1:0] clock_out_divide_reg;
    logic int_osc_ready_reg;
    logic [7:0] int_cnt_reg;
    logic [7:0] xtal_cnt_reg;
    logic int_prev_reg;
    logic ext_prev_reg;
    logic int_gate_reg;
    scs_src_t target_src_reg;
    scs_src_t active_src_reg;
    scs_src_t active_next;
    logic int_div_level;
    logic clk_out_level;
    logic target_level;
    logic target_ready;
    logic wr_osc;
    logic wr_sel;

    assign wr_osc = sfr_write && (sfr_addr == SCS_ADDR_OSCCTL);
    assign wr_sel = sfr_write && (sfr_addr == SCS_ADDR_CLOCK_SOURCE_SELECT_REG);

    // internal oscillator control register
    always_ff @(posedge clock) begin
        if (reset) begin
            int_osc_enable <= SCS_OSCCTL_RESET[SCS_OSC_EN_BIT];
            int_osc_divide_reg <= SCS_OSCCTL_RESET[SCS_OSC_DIV_LSB +: 2];
        end else if (wr_osc) begin
            int_osc_enable <= sfr_wdata[SCS_OSC_EN_BIT];
            int_osc_divide_reg <= sfr_wdata[SCS_OSC_DIV_LSB +: 2];
        end
    end

    // enable reaches the prescaler only while the oscillator level is low,
    // so turning it on or off mid-high cannot cut a short pulse
    always_ff @(posedge clock) begin
        if (reset) begin
            int_gate_reg <= SCS_OSCCTL_RESET[SCS_OSC_EN_BIT];
        end else if (!int_osc_in) begin
            int_gate_reg <= int_osc_enable;
        end
    end

    // source select register; reserved code kept readable but not acted on
    always_ff @(posedge clock) begin
        if (reset) begin
            core_clock_source_reg <= SCS_CLOCK_SOURCE_SELECT_REG_RESET[SCS_SEL_LSB +: 2];
            clock_out_divide_reg <= SCS_CLOCK_SOURCE_SELECT_REG_RESET[SCS_OUTDIV_LSB +: 2];
            target_src_reg <= SCS_SRC_INT;
        end else if (wr_sel) begin
            core_clock_source_reg <= sfr_wdata[SCS_SEL_LSB +: 2];
            clock_out_divide_reg <= sfr_wdata[SCS_OUTDIV_LSB +: 2];
            case (sfr_wdata[SCS_SEL_LSB +: 2])
                SCS_CODE_INT: target_src_reg <= SCS_SRC_INT;
                SCS_CODE_EXT: target_src_reg <= SCS_SRC_EXT;
                SCS_CODE_PLL: target_src_reg <= SCS_SRC_PLL;
                default: target_src_reg <= target_src_reg;
            endcase
        end
    end

    // internal oscillator settle count; oscillator assumed running at reset
    always_ff @(posedge clock) begin
        if (reset) begin
            int_prev_reg <= 1'b0;
            int_cnt_reg <= INT_SETTLE;
            int_osc_ready_reg <= 1'b1;
        end else begin
            int_prev_reg <= int_osc_in;
            if (!int_osc_enable) begin
                int_cnt_reg <= 8'h00;
                int_osc_ready_reg <= 1'b0;
            end else if (int_cnt_reg == INT_SETTLE) begin
                int_osc_ready_reg <= 1'b1;
            end else if (int_osc_in && !int_prev_reg) begin
                int_cnt_reg <= int_cnt_reg + 8'h01;
            end
        end
    end

    // crystal valid after enough external edges; restarts when disabled
    always_ff @(posedge clock) begin
        if (reset) begin
            ext_prev_reg <= 1'b0;
            xtal_cnt_reg <= 8'h00;
            crystal_valid <= 1'b0;
        end else begin
            ext_prev_reg <= ext_osc_in;
            if (!ext_osc_enable) begin
                xtal_cnt_reg <= 8'h00;
                crystal_valid <= 1'b0;
            end else if (xtal_cnt_reg == XTAL_SETTLE) begin
                crystal_valid <= 1'b1;
            end else if (ext_osc_in && !ext_prev_reg) begin
                xtal_cnt_reg <= xtal_cnt_reg + 8'h01;
            end
        end
    end

    // lock flag and peripheral clock copy
    always_ff @(posedge clock) begin
        if (reset) begin
            pll_locked <= 1'b0;
            ext_periph_clock <= 1'b0;
        end else begin
            pll_locked <= pll_lock_in;
            ext_periph_clock <= ext_osc_in;
        end
    end

    // internal prescaler: code 00 is the slowest, hence the inverted shift
    scs_div u_int_div (
        .clock(clock),
        .reset(reset),
        .src_level(int_osc_in && int_gate_reg),
        .shift(SCS_SHIFT_MAX - int_osc_divide_reg),
        .div_out(int_div_level)
    );

    // target level and readiness
    always_comb begin
        case (target_src_reg)
            SCS_SRC_EXT: begin
                target_level = ext_osc_in;
                target_ready = crystal_valid;
            end
            SCS_SRC_PLL: begin
                target_level = pll_clk_in;
                target_ready = pll_locked;
            end
            default: begin
                target_level = int_div_level;
                target_ready = int_osc_ready_reg;
            end
        endcase
    end

    // switch only while old output and new source are both low
    always_comb begin
        active_next = active_src_reg;
        if (target_src_reg != active_src_reg && !core_clock && !target_level
            && target_ready) begin
            active_next = target_src_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            active_src_reg <= SCS_SRC_INT;
            core_clock <= 1'b0;
        end else begin
            active_src_reg <= active_next;
            case (active_next)
                SCS_SRC_EXT: core_clock <= ext_osc_in;
                SCS_SRC_PLL: core_clock <= pll_clk_in;
                default: core_clock <= int_div_level;
            endcase
        end
    end

    // port pin clock divider
    scs_div u_out_div (
        .clock(clock),
        .reset(reset),
        .src_level(core_clock),
        .shift(clock_out_divide_reg),
        .div_out(clk_out_level)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            clock_out <= 1'b0;
        end else begin
            clock_out <= clk_out_level;
        end
    end

    // registered read port; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            sfr_rdata <= SCS_RDATA_IDLE;
        end else if (sfr_addr == SCS_ADDR_OSCCTL) begin
            sfr_rdata <= {int_osc_enable, int_osc_ready_reg, 4'h0, int_osc_divide_reg};
        end else if (sfr_addr == SCS_ADDR_CLOCK_SOURCE_SELECT_REG) begin
            sfr_rdata <= {2'h0, clock_out_divide_reg, 2'h0, core_clock_source_reg};
        end else begin
            sfr_rdata <= SCS_RDATA_IDLE;
        end
    end

    AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (reset)
        wr_osc |=> int_osc_enable == $past(sfr_wdata[SCS_OSC_EN_BIT]))
        else $error("enable bit did not follow write");
    AST_READY_OFF: assert property (@(posedge clock) disable iff (reset)
        !int_osc_enable |=> !int_osc_ready_reg)
        else $error("ready set while oscillator disabled");
    AST_RESERVED_KEEP: assert property (@(posedge clock) disable iff (reset)
        (wr_sel && sfr_wdata[SCS_SEL_LSB +: 2] == SCS_CODE_RSVD) |=> $stable(target_src_reg))
        else $error("reserved code changed the source");
    AST_SWITCH_LOW: assert property (@(posedge clock) disable iff (reset)
        (active_src_reg != $past(active_src_reg)) |-> $past(!core_clock))
        else $error("switch while core clock high");
    AST_SWITCH_SETTLED: assert property (@(posedge clock) disable iff (reset)
        (active_src_reg != $past(active_src_reg) && active_src_reg == SCS_SRC_EXT)
        |-> $past(crystal_valid))
        else $error("switched to unsettled external source");
    AST_RESET_INT: assert property (@(posedge clock)
        reset |=> active_src_reg == SCS_SRC_INT && target_src_reg == SCS_SRC_INT)
        else $error("reset did not select internal source");
    AST_XTAL_DROP: assert property (@(posedge clock) disable iff (reset)
        !ext_osc_enable ##1 ext_osc_enable [*2] |-> !crystal_valid)
        else $error("crystal valid without settle time");
    AST_PERIPH_CLK: assert property (@(posedge clock) disable iff (reset)
        !$past(reset) |-> ext_periph_clock == $past(ext_osc_in))
        else $error("peripheral clock lost external source");
    AST_PLL_LOCK: assert property (@(posedge clock) disable iff (reset)
        $rose(pll_lock_in) |=> pll_locked)
        else $error("lock flag missed");
endmodule : scs_clock_select
`default_nettype wire

/* File: scs_div.sv */
/*
 * Power-of-two divider for a slowly toggling clock level that is sampled
 * on the fast block clock. Output is the source divided by 2**shift; a
 * new ratio is taken only while output and new tap are both low.
 * Assumes the source level is synchronous to clock and toggles slower
 * than half the clock rate.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_div
    import scs_pkg::*;
(
    input wire logic clock, // block clock
    input wire logic reset, // synchronous, active high
    input wire logic src_level, // source clock level
    input wire logic [1:0] shift, // 0: /1, 1: /2, 2: /4, 3: /8
    output logic div_out // divided level, registered
);
    logic prev_reg;
    logic [2:0] count_reg;
    logic [1:0] shift_reg;
    logic [3:0] taps;
    logic adopt;
    logic div_next;

    // count rising edges of the source
    always_ff @(posedge clock) begin
        if (reset) begin
            prev_reg <= 1'b0;
            count_reg <= 3'h0;
        end else begin
            prev_reg <= src_level;
            if (src_level && !prev_reg) begin
                count_reg <= count_reg + 3'h1;
            end
        end
    end

    // tap 0 is the source itself, then the counter bits for /2, /4, /8
    assign taps = {count_reg, src_level};
    // switching taps at once could cut a one-cycle pulse, so the new ratio
    // waits until the output has been low a cycle and the new tap is low
    assign adopt = (shift != shift_reg) && !div_out && !taps[shift];
    assign div_next = adopt ? 1'b0 : taps[shift_reg];

    always_ff @(posedge clock) begin
        if (reset) begin
            shift_reg <= shift;
            div_out <= 1'b0;
        end else begin
            if (adopt) begin
                shift_reg <= shift;
            end
            div_out <= div_next;
        end
    end
endmodule : scs_div
`default_nettype wire

/* File: scs_osc_model.sv */
/*
 * Far-side model: internal oscillator, external crystal and PLL levels.
 * Assumes the 25 MHz block clock; every level moves just after its edge.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_osc_model (
    input wire logic clock, // block clock
    input wire logic ext_run, // external circuit enabled
    input wire logic pll_run, // PLL powered
    output logic int_osc, // internal level, period 4 cycles
    output logic ext_osc, // crystal level, period 6 cycles
    output logic pll_clk, // PLL level, period 8 cycles
    output logic pll_lock // raw lock, late after power-up
);
    logic [1:0] int_cnt = 2'h0;
    logic [2:0] ext_cnt = 3'h0;
    logic [2:0] pll_cnt = 3'h0;
    logic [4:0] lock_cnt = 5'h00;
    // crystal stands still while its circuit is off
    always_ff @(posedge clock) begin
        int_cnt <= int_cnt + 2'h1;
        if (ext_run) begin
            ext_cnt <= (ext_cnt == 3'h5) ? 3'h0 : ext_cnt + 3'h1;
        end
    end
    // lock only after a settle time, so early selection is exposed
    always_ff @(posedge clock) begin
        if (pll_run) begin
            pll_cnt <= pll_cnt + 3'h1;
            lock_cnt <= (lock_cnt == 5'h14) ? lock_cnt : lock_cnt + 5'h01;
        end else begin
            lock_cnt <= 5'h00;
        end
    end
    // levels from the counters
    assign int_osc = int_cnt[1];
    assign ext_osc = (ext_cnt >= 3'h3);
    assign pll_clk = pll_cnt[2];
    assign pll_lock = (lock_cnt == 5'h14);
endmodule : scs_osc_model
`default_nettype wire

/* File: scs_pkg.sv */
/*
 * Shared constants for the core clock source selector: special function
 * register addresses, field positions, reset values and source codes.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package scs_pkg;
    // register addresses on the special function register port
    localparam logic [7:0] SCS_ADDR_CLOCK_SOURCE_SELECT_REG = 8'h97;
    localparam logic [7:0] SCS_ADDR_OSCCTL = 8'h8A;
    // reset values
    localparam logic [7:0] SCS_CLOCK_SOURCE_SELECT_REG_RESET = 8'h00;
    localparam logic [7:0] SCS_OSCCTL_RESET = 8'hC0;
    localparam logic [7:0] SCS_RDATA_IDLE = 8'h00;
    // internal oscillator control field positions
    localparam int SCS_OSC_EN_BIT = 7;
    localparam int SCS_OSC_RDY_BIT = 6;
    localparam int SCS_OSC_DIV_LSB = 0;
    // source select register field positions
    localparam int SCS_SEL_LSB = 0;
    localparam int SCS_OUTDIV_LSB = 4;
    // source select codes
    localparam logic [1:0] SCS_CODE_INT = 2'h0;
    localparam logic [1:0] SCS_CODE_EXT = 2'h1;
    localparam logic [1:0] SCS_CODE_PLL = 2'h2;
    localparam logic [1:0] SCS_CODE_RSVD = 2'h3;
    // largest divide shift (divide by 8)
    localparam logic [1:0] SCS_SHIFT_MAX = 2'h3;
    typedef enum logic [1:0] {SCS_SRC_INT, SCS_SRC_EXT, SCS_SRC_PLL} scs_src_t;
endpackage : scs_pkg

/* File: tb.sv */
/*
 * Self-checking bench for the core clock source selector.
 * Assumes the oscillator model as far side and register port timing of
 * one-cycle write strobe and registered read data.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import scs_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sfr_write = 1'b0;
    logic ext_run = 1'b0;
    logic pll_run = 1'b0;
    logic armed = 1'b0;
    logic last_core = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] rd;
    wire [7:0] sfr_rdata;
    wire int_osc_in, ext_osc_in, pll_clk_in, pll_lock_in, core_clock, clock_out;
    wire ext_periph_clock, int_osc_enable, crystal_valid, pll_locked;
    wire [2:0] probe = {ext_periph_clock, clock_out, core_clock};
    int n_errors = 0;
    int tests_run = 0;
    int run_len = 0;
    int i;

    scs_clock_select u_scs_clock_select (.clock(clock), .reset(reset),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
        .sfr_rdata(sfr_rdata), .int_osc_in(int_osc_in), .ext_osc_in(ext_osc_in),
        .ext_osc_enable(ext_run), .pll_clk_in(pll_clk_in), .pll_lock_in(pll_lock_in),
        .core_clock(core_clock), .clock_out(clock_out), .ext_periph_clock(ext_periph_clock),
        .int_osc_enable(int_osc_enable), .crystal_valid(crystal_valid),
        .pll_locked(pll_locked));
    scs_osc_model u_scs_osc_model (.clock(clock), .ext_run(ext_run), .pll_run(pll_run),
        .int_osc(int_osc_in), .ext_osc(ext_osc_in), .pll_clk(pll_clk_in),
        .pll_lock(pll_lock_in));

    always #20 clock = ~clock;

    task final_report;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        n_errors++;
    endtask : fail
    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) fail("register read");
    endtask : chk_reg
    task chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) fail("status flag");
    endtask : chk_bit
    task chk_per(input int got, input int exp);
        tests_run++;
        if (got != exp) fail("clock period");
    endtask : chk_per
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clock);
        sfr_write <= 1'b0;
    endtask : wr
    task rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        @(posedge clock);
        #1 d = sfr_rdata;
    endtask : rd8
    // cycles between two rising edges; bounded so a dead clock ends the run
    task per(input int idx, output int p);
        int r;
        logic last;
        r = 0;
        p = 0;
        last = probe[idx];
        for (int k = 0; k < 400 && r < 2; k++) begin
            @(posedge clock);
            #1;
            if (r == 1) p++;
            if (probe[idx] === 1'b1 && last === 1'b0) r++;
            last = probe[idx];
        end
        if (r < 2) begin
            fail("clock stopped");
            final_report;
        end
    endtask : per
    // first period after a change may be cut, so it is thrown away
    task exp_per(input int idx, input int e);
        int p;
        per(idx, p);
        per(idx, p);
        chk_per(p, e);
    endtask : exp_per

    // no level of the core clock may last a single cycle once started
    always @(posedge clock) begin
        last_core <= core_clock;
        if (reset) begin
            armed <= 1'b0;
        end else if (core_clock !== last_core) begin
            if (armed && run_len == 0) fail("short core pulse");
            armed <= 1'b1;
            run_len <= 0;
        end else begin
            run_len <= run_len + 1;
        end
    end

    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd8(SCS_ADDR_OSCCTL, rd);
        chk_reg(rd, SCS_OSCCTL_RESET);
        rd8(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, rd);
        chk_reg(rd, SCS_CLOCK_SOURCE_SELECT_REG_RESET);
        chk_bit(crystal_valid, 1'b0);
        chk_bit(pll_locked, 1'b0);
        exp_per(0, 32);
        wr(SCS_ADDR_OSCCTL, 8'h03);
        rd8(SCS_ADDR_OSCCTL, rd);
        chk_reg(rd, 8'h03);
        chk_bit(int_osc_enable, 1'b0);
        wr(SCS_ADDR_OSCCTL, 8'h83);
        #1 chk_bit(int_osc_enable, 1'b1);
        repeat (40) @(posedge clock);
        rd8(SCS_ADDR_OSCCTL, rd);
        chk_reg(rd, 8'hC3);
        for (i = 0; i < 4; i++) begin
            wr(SCS_ADDR_OSCCTL, {6'h20, i[1:0]});
            exp_per(0, 32 >> i);
        end
        for (i = 0; i < 4; i++) begin
            wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {2'h0, i[1:0], 4'h0});
            exp_per(1, 4 << i);
        end
        // reserved bits drop, unmapped address takes nothing
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, 8'hCC);
        rd8(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, rd);
        chk_reg(rd, 8'h00);
        wr(8'h20, 8'h55);
        rd8(8'h20, rd);
        chk_reg(rd, SCS_RDATA_IDLE);
        rd8(SCS_ADDR_OSCCTL, rd);
        chk_reg(rd, 8'hC3);
        // an unsettled crystal must not take over
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {6'h00, SCS_CODE_EXT});
        exp_per(0, 4);
        @(posedge clock);
        ext_run <= 1'b1;
        repeat (25000) @(posedge clock);
        chk_bit(crystal_valid, 1'b1);
        exp_per(0, 6);
        // reserved code while external runs: external must stay
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {6'h00, SCS_CODE_RSVD});
        rd8(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, rd);
        chk_reg(rd, 8'h03);
        exp_per(0, 6);
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {6'h00, SCS_CODE_INT});
        exp_per(2, 6);
        // PLL picked before it runs: internal must stay until lock
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {6'h00, SCS_CODE_PLL});
        exp_per(0, 4);
        @(posedge clock);
        pll_run <= 1'b1;
        for (i = 0; i < 100 && pll_locked !== 1'b1; i++) @(posedge clock);
        if (pll_locked !== 1'b1) begin
            fail("lock wait ran out");
            final_report;
        end
        chk_bit(pll_locked, 1'b1);
        wr(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, {6'h00, SCS_CODE_PLL});
        exp_per(0, 8);
        // second reset in mid-run
        @(posedge clock);
        reset <= 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd8(SCS_ADDR_CLOCK_SOURCE_SELECT_REG, rd);
        chk_reg(rd, SCS_CLOCK_SOURCE_SELECT_REG_RESET);
        exp_per(0, 32);
        final_report;
    end
endmodule : tb
`default_nettype wire
